// *** hdl/irq_cmd_map.svh ***
`ifndef IRQ_CMD_MAP_SVH
`define IRQ_CMD_MAP_SVH

// byte addresses of the two ports
`define ADDR_STATUS_CMD     20'h9fff0
`define ADDR_LINE_MASK      20'h9fff2

// command codes
`define CMD_NONSPEC_CLEAR   8'h20
`define CMD_ROT_NONSPEC     8'ha0
`define CMD_AUTO_ROT_ON     8'h40
`define CMD_AUTO_ROT_OFF    8'h00
`define CMD_SEL_IN_SERVICE  8'h0b
`define CMD_SEL_PENDING     8'h0a
`define CMD_POLL            8'h0c
`define CMD_SPECIAL_ON      8'h68
`define CMD_SPECIAL_OFF     8'h48

// high five bits of the commands that carry a line number
`define CMD_SPEC_HI         5'h0c
`define CMD_ROT_SPEC_HI     5'h1c
`define CMD_SET_LOW_HI      5'h18

// reset values
`define RST_LOWEST_LINE     3'h7
`define RST_MASK            8'h00
`define RST_BYTE            8'h00
`define RST_ACK_LINE        3'h0

// poll answer layout
`define POLL_VALID_BIT      7
`define POLL_NONE           8'h00

`endif

// *** hdl/irq_pkg.sv ***
package irq_pkg;
    typedef logic [7:0] line_vec_t;
    typedef logic [2:0] line_num_t;
endpackage

// *** hdl/prio_resolve_if.sv ***
interface prio_resolve_if;
    irq_pkg::line_vec_t candidates;
    irq_pkg::line_num_t lowest;
    logic               found;
    irq_pkg::line_num_t winner;

    modport requester
    (
        output candidates,
        output lowest,
        input  found,
        input  winner
    );
    modport resolver
    (
        input  candidates,
        input  lowest,
        output found,
        output winner
    );
endinterface

// *** hdl/prio_resolve.sv ***
// picks the highest priority set bit; priority falls from lowest+1 round
// to lowest
module prio_resolve
(
    prio_resolve_if.resolver pr
);
    irq_pkg::line_vec_t hit;

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1)
        begin : g_rank
            // line at rank g counting from the highest
            logic [2:0] idx;
            assign idx = 3'(pr.lowest + 3'(g) + 3'h1);
            assign hit[g] = pr.candidates[idx];
        end
    endgenerate

    always_comb
    begin
        pr.found  = 1'b0;
        pr.winner = 3'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (hit[i])
            begin
                pr.found  = 1'b1;
                pr.winner = 3'(pr.lowest + 3'(i) + 3'h1);
            end
        end
    end
endmodule

// *** hdl/priority_interrupt_command_logic.sv ***
module priority_interrupt_command_logic
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic [19:0] addr,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    input  wire logic [7:0]  wr_data,
    output logic      [7:0]  rd_data,
    input  wire logic [7:0]  request_lines,
    input  wire logic        edge_mode,
    input  wire logic        auto_service_end_mode,
    input  wire logic        int_ack,
    output logic             int_req,
    output logic      [2:0]  ack_line
);
`include "irq_cmd_map.svh"

    // ======================================================
    // register state
    irq_pkg::line_vec_t pending_request_reg_ff;
    irq_pkg::line_vec_t nxt_pending_request_reg;
    irq_pkg::line_vec_t in_service_reg_ff;
    irq_pkg::line_vec_t nxt_in_service_reg;
    irq_pkg::line_vec_t line_mask_reg_ff;
    irq_pkg::line_vec_t nxt_line_mask_reg;
    irq_pkg::line_vec_t req_prev_ff;
    irq_pkg::line_num_t lowest_ff;
    irq_pkg::line_num_t nxt_lowest;
    logic               read_in_service_ff;
    logic               nxt_read_in_service;
    logic               special_mask_ff;
    logic               nxt_special_mask;
    logic               auto_rotate_ff;
    logic               nxt_auto_rotate;
    logic               poll_armed_ff;
    logic               nxt_poll_armed;
    logic [7:0]         poll_answer_ff;
    logic [7:0]         nxt_poll_answer;
    logic [7:0]         rd_data_ff;
    logic [7:0]         nxt_rd_data;
    logic               int_req_ff;
    logic               nxt_int_req;
    irq_pkg::line_num_t ack_line_ff;
    irq_pkg::line_num_t nxt_ack_line;

    // ======================================================
    // priority resolvers
    prio_resolve_if isr_pr ();
    prio_resolve_if req_pr ();
    prio_resolve u_isr_res (.pr (isr_pr.resolver));
    prio_resolve u_req_res (.pr (req_pr.resolver));
    irq_pkg::line_vec_t unmasked_req;
    irq_pkg::line_vec_t blocked;
    irq_pkg::line_vec_t eligible;

    assign isr_pr.candidates = in_service_reg_ff;
    assign isr_pr.lowest     = lowest_ff;

    assign unmasked_req = pending_request_reg_ff & ~line_mask_reg_ff;

    // equal and lower priorities blocked by top in-service level
    always_comb
    begin
        blocked = 8'h00;
        if (!special_mask_ff && isr_pr.found)
        begin
            for (int r = 0; r < 8; r++)
            begin
                // walk from the active level down to lowest
                if (3'(isr_pr.winner - lowest_ff - 3'h1) <= 3'(r))
                begin
                    blocked[3'(lowest_ff + 3'(r) + 3'h1)] = 1'b1;
                end
            end
        end
    end

    // in special mask mode only the serviced lines themselves drop out
    assign eligible = unmasked_req & ~blocked
                      & (special_mask_ff ? ~in_service_reg_ff : 8'hff);

    assign req_pr.candidates = eligible;
    assign req_pr.lowest     = lowest_ff;

    // ======================================================
    // command decode
    logic       cmd_wr;
    logic       mask_wr;
    logic       status_rd;
    logic       grp_service;
    logic       grp_status;
    logic [2:0] cmd_line;
    logic [4:0] cmd_hi;

    assign cmd_wr    = wr_en && (addr == `ADDR_STATUS_CMD);
    assign mask_wr   = wr_en && (addr == `ADDR_LINE_MASK);
    assign status_rd = rd_en && (addr == `ADDR_STATUS_CMD);
    assign cmd_line  = wr_data[2:0];
    assign cmd_hi    = wr_data[7:3];
    // group select by bits 4 and 3
    assign grp_service = cmd_wr && !wr_data[4] && !wr_data[3];
    assign grp_status  = cmd_wr && !wr_data[4] && wr_data[3];

    // ======================================================
    // next state
    always_comb
    begin
        irq_pkg::line_vec_t req_now;
        irq_pkg::line_vec_t req_set;
        irq_pkg::line_vec_t isr_set;
        req_now                 = request_lines;
        nxt_pending_request_reg = pending_request_reg_ff;
        nxt_in_service_reg      = in_service_reg_ff;
        nxt_line_mask_reg       = line_mask_reg_ff;
        nxt_lowest              = lowest_ff;
        nxt_read_in_service     = read_in_service_ff;
        nxt_special_mask        = special_mask_ff;
        nxt_auto_rotate         = auto_rotate_ff;
        nxt_poll_armed          = poll_armed_ff;
        nxt_poll_answer         = poll_answer_ff;
        nxt_rd_data             = rd_data_ff;
        nxt_ack_line            = ack_line_ff;
        isr_set                 = 8'h00;
        // level lines follow the input; edge lines latch rising edges
        req_set = edge_mode ? (req_now & ~req_prev_ff) : req_now;
        // hardware acknowledge; ignored while a poll is armed
        // acknowledge moves top request into service, except in auto end mode
        if (int_ack && !poll_armed_ff && req_pr.found)
        begin
            nxt_pending_request_reg[req_pr.winner] = 1'b0;
            nxt_ack_line = req_pr.winner;
            // auto end clears at service entry
            if (!auto_service_end_mode)
            begin
                isr_set[req_pr.winner] = 1'b1;
            end
            // auto rotation only in auto end mode
            if (auto_service_end_mode && auto_rotate_ff)
            begin
                nxt_lowest = req_pr.winner;
            end
        end

        if (status_rd)
        begin
            if (poll_armed_ff)
            begin
                nxt_rd_data    = poll_answer_ff;
                nxt_poll_armed = 1'b0;
                if (poll_answer_ff[`POLL_VALID_BIT])
                begin
                    nxt_pending_request_reg[poll_answer_ff[2:0]] = 1'b0;
                    isr_set[poll_answer_ff[2:0]]                 = 1'b1;
                end
            end
            else if (read_in_service_ff)
            begin
                nxt_rd_data = in_service_reg_ff;
            end
            else
            begin
                nxt_rd_data = pending_request_reg_ff;
            end
        end
        else if (rd_en && addr == `ADDR_LINE_MASK)
        begin
            nxt_rd_data = line_mask_reg_ff;
        end

        // freeze the top request; a poll write beats a read clear
        if (grp_status && wr_data == `CMD_POLL)
        begin
            nxt_poll_armed  = 1'b1;
            nxt_poll_answer = `POLL_NONE;
            if (req_pr.found)
            begin
                nxt_poll_answer = {1'b1, 4'h0, req_pr.winner};
            end
        end

        if (mask_wr)
        begin
            nxt_line_mask_reg = wr_data;
        end

        if (grp_service)
        begin
            if (wr_data == `CMD_NONSPEC_CLEAR)
            begin
                // clear top bit; with none set bit 0 is already clear
                nxt_in_service_reg[isr_pr.winner] = 1'b0;
            end
            else if (wr_data == `CMD_ROT_NONSPEC)
            begin
                if (isr_pr.found)
                begin
                    nxt_in_service_reg[isr_pr.winner] = 1'b0;
                    nxt_lowest = isr_pr.winner;
                end
            end
            else if (cmd_hi == `CMD_SPEC_HI)
            begin
                nxt_in_service_reg[cmd_line] = 1'b0;
            end
            else if (cmd_hi == `CMD_ROT_SPEC_HI)
            begin
                nxt_in_service_reg[cmd_line] = 1'b0;
                nxt_lowest = cmd_line;
            end
            else if (cmd_hi == `CMD_SET_LOW_HI)
            begin
                nxt_lowest = cmd_line;
            end
            else if (wr_data == `CMD_AUTO_ROT_ON)
            begin
                nxt_auto_rotate = 1'b1;
            end
            else if (wr_data == `CMD_AUTO_ROT_OFF)
            begin
                nxt_auto_rotate = 1'b0;
            end
        end

        if (grp_status)
        begin
            if (wr_data == `CMD_SEL_IN_SERVICE)
            begin
                nxt_read_in_service = 1'b1;
            end
            else if (wr_data == `CMD_SEL_PENDING)
            begin
                nxt_read_in_service = 1'b0;
            end
            else if (wr_data == `CMD_SPECIAL_ON)
            begin
                nxt_special_mask = 1'b1;
            end
            else if (wr_data == `CMD_SPECIAL_OFF)
            begin
                nxt_special_mask = 1'b0;
            end
        end

        // new requests and service entries win over clears in one cycle
        nxt_pending_request_reg = nxt_pending_request_reg | req_set;
        nxt_in_service_reg      = nxt_in_service_reg | isr_set;
        if (!edge_mode)
        begin
            // level lines drop when the input drops
            nxt_pending_request_reg = nxt_pending_request_reg & req_now;
        end

        nxt_int_req = req_pr.found && !poll_armed_ff && !nxt_poll_armed;
    end

    // ======================================================
    // registers
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pending_request_reg_ff <= `RST_MASK;
            in_service_reg_ff      <= `RST_MASK;
            line_mask_reg_ff       <= `RST_MASK;
            req_prev_ff            <= `RST_MASK;
            lowest_ff              <= `RST_LOWEST_LINE;
            read_in_service_ff     <= 1'b0;
            special_mask_ff        <= 1'b0;
            auto_rotate_ff         <= 1'b0;
            poll_armed_ff          <= 1'b0;
            poll_answer_ff         <= `RST_BYTE;
            rd_data_ff             <= `RST_BYTE;
            int_req_ff             <= 1'b0;
            ack_line_ff            <= `RST_ACK_LINE;
        end
        else
        begin
            pending_request_reg_ff <= nxt_pending_request_reg;
            in_service_reg_ff      <= nxt_in_service_reg;
            line_mask_reg_ff       <= nxt_line_mask_reg;
            req_prev_ff            <= request_lines;
            lowest_ff              <= nxt_lowest;
            read_in_service_ff     <= nxt_read_in_service;
            special_mask_ff        <= nxt_special_mask;
            auto_rotate_ff         <= nxt_auto_rotate;
            poll_armed_ff          <= nxt_poll_armed;
            poll_answer_ff         <= nxt_poll_answer;
            rd_data_ff             <= nxt_rd_data;
            int_req_ff             <= nxt_int_req;
            ack_line_ff            <= nxt_ack_line;
        end
    end

    assign rd_data  = rd_data_ff;
    assign int_req  = int_req_ff;
    assign ack_line = ack_line_ff;
endmodule

// *** testbench/irq_cmd_asserts.sv ***
`include "irq_cmd_map.svh"

module irq_cmd_asserts
(
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic [19:0] addr,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [7:0]  wr_data,
    input wire logic [7:0]  rd_data,
    input wire logic [7:0]  request_lines,
    input wire logic        edge_mode,
    input wire logic        auto_service_end_mode,
    input wire logic        int_ack,
    input wire logic        int_req,
    input wire logic [2:0]  ack_line
);
    timeunit 1ns;
    timeprecision 1ns;

    // ================================================================
    // shadow of mask and poll state
    logic [7:0] mask_ff;
    logic [7:0] nxt_mask;
    logic [7:0] mask_d_ff;
    logic       poll_ff;
    logic       nxt_poll;
    logic       st_wr;
    logic       st_rd;

    assign st_wr = wr_en && addr == `ADDR_STATUS_CMD;
    assign st_rd = rd_en && addr == `ADDR_STATUS_CMD;

    always_comb
    begin
        nxt_mask = mask_ff;
        nxt_poll = poll_ff;
        if (wr_en && addr == `ADDR_LINE_MASK)
            nxt_mask = wr_data;
        if (st_rd)
            nxt_poll = 1'b0;
        if (st_wr && wr_data == `CMD_POLL)
            nxt_poll = 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            mask_ff   <= `RST_MASK;
            mask_d_ff <= `RST_MASK;
            poll_ff   <= 1'b0;
        end
        else
        begin
            mask_ff   <= nxt_mask;
            mask_d_ff <= mask_ff;
            poll_ff   <= nxt_poll;
        end
    end

    // ================================================================
    // properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_reset_values:
    assert property ($fell(sys_rst) |-> rd_data == 8'h00 && !int_req
                     && ack_line == 3'h0)
    else $error("outputs not cleared by reset");

    a_mask_read:
    assert property (rd_en && addr == `ADDR_LINE_MASK
                     |=> rd_data == $past(mask_ff))
    else $error("mask read differs from last mask write");

    a_rd_hold:
    assert property (!(rd_en && (addr == `ADDR_STATUS_CMD
                     || addr == `ADDR_LINE_MASK)) |=> $stable(rd_data))
    else $error("read data moved without a decoded read");

    a_ack_hold:
    assert property (!int_ack |=> $stable(ack_line))
    else $error("ack line moved without acknowledge");

    a_ack_unmasked:
    assert property ($changed(ack_line) |-> !mask_d_ff[ack_line])
    else $error("masked line taken by acknowledge");

    a_all_masked:
    assert property (mask_ff == 8'hff |=> !int_req)
    else $error("request raised with every line masked");

    a_poll_quiet:
    assert property (st_wr && wr_data == `CMD_POLL |=> ##1 !int_req)
    else $error("request still raised after poll command");

    a_poll_format:
    assert property (st_rd && poll_ff |=> rd_data[6:3] == 4'h0
                     && (rd_data[7] || rd_data == `POLL_NONE))
    else $error("poll answer badly formed");
endmodule

bind priority_interrupt_command_logic irq_cmd_asserts irq_cmd_asserts_inst
(
    .sys_clk, .sys_rst, .addr, .wr_en, .rd_en, .wr_data, .rd_data,
    .request_lines, .edge_mode, .auto_service_end_mode, .int_ack,
    .int_req, .ack_line
);

// *** testbench/host_model.sv ***
`include "irq_cmd_map.svh"

module host_model
(
    input  wire logic        sys_clk,
    input  wire logic [7:0]  rd_data,
    output logic      [19:0] addr,
    output logic             wr_en,
    output logic             rd_en,
    output logic      [7:0]  wr_data,
    output logic             int_ack
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        addr    = `ADDR_LINE_MASK;
        wr_en   = 1'b0;
        rd_en   = 1'b0;
        wr_data = 8'h00;
        int_ack = 1'b0;
    end

    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge sys_clk);
        wr_en   <= 1'b0;
        // released data bus must not keep showing the byte
        wr_data <= ~d;
    endtask

    task automatic rd(input logic [19:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask

    task automatic ack();
        @(posedge sys_clk);
        int_ack <= 1'b1;
        @(posedge sys_clk);
        int_ack <= 1'b0;
        #1;
    endtask
endmodule

// *** testbench/tb.sv ***
`include "irq_cmd_map.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [19:0] sa = `ADDR_STATUS_CMD;
    localparam logic [19:0] ma = `ADDR_LINE_MASK;

    logic        sys_clk;
    logic        sys_rst;
    logic [19:0] addr;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;
    logic [7:0]  request_lines;
    logic        edge_mode;
    logic        auto_service_end_mode;
    logic        int_ack;
    logic        int_req;
    logic [2:0]  ack_line;
    int          n_mismatch;
    int          tests_run;
    logic [7:0]  r;
    logic [7:0]  m;
    logic [2:0]  n;
    logic [2:0]  low;

    priority_interrupt_command_logic priority_interrupt_command_logic_inst
    (
        .sys_clk, .sys_rst, .addr, .wr_en, .rd_en, .wr_data, .rd_data,
        .request_lines, .edge_mode, .auto_service_end_mode, .int_ack,
        .int_req, .ack_line
    );

    host_model host_model_inst
    (
        .sys_clk, .rd_data, .addr, .wr_en, .rd_en, .wr_data, .int_ack
    );

    always #25 sys_clk = ~sys_clk;

    // circular order: lw+1 wins, lw loses
    function automatic logic [2:0] top(input logic [7:0] v,
                                       input logic [2:0] lw);
        logic [2:0] l;
        top = lw;
        for (int i = 8; i >= 1; i--)
        begin
            l = lw + 3'(i);
            if (v[l])
                top = l;
        end
    endfunction

    task automatic final_report();
        $display("mismatches %0d checks %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [19:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_model_inst.rd(a, d);
        check(d, exp);
    endtask

    // bounded wait, then acknowledge and compare the taken line
    task automatic take(input logic [2:0] lw);
        for (int i = 0; i < 100 && int_req !== 1'b1; i++)
        begin
            @(posedge sys_clk);
            #1;
        end
        if (int_req !== 1'b1)
        begin
            n_mismatch++;
            final_report();
        end
        else
        begin
            host_model_inst.ack();
            n = top(r & ~m, lw);
            check({5'h00, ack_line}, {5'h00, n});
            r[n] = 1'b0;
        end
    endtask

    task automatic req_is(input logic [7:0] exp);
        repeat (2) @(posedge sys_clk);
        #1 check({7'h00, int_req}, exp);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        sys_rst = 1'b1;
        request_lines = 8'h00;
        edge_mode = 1'b1;
        auto_service_end_mode = 1'b0;
        n_mismatch = 0;
        tests_run = 0;
        void'($urandom(52));
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rdchk(ma, 8'h00);
        rdchk(sa, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            m = (i == 0) ? 8'hff : (i == 3) ? 8'h00 : 8'($urandom);
            host_model_inst.wr(ma, m);
            rdchk(ma, m);
        end
        host_model_inst.wr(20'h9fff6, 8'hff);
        rdchk(20'h9fff4, 8'h00);
        rdchk(ma, 8'h00);
        host_model_inst.wr(sa, `CMD_POLL);
        rdchk(sa, `POLL_NONE);
        r = 8'($urandom) | 8'h1f;
        @(posedge sys_clk);
        request_lines <= r;
        repeat (3) @(posedge sys_clk);
        rdchk(sa, r);
        host_model_inst.wr(sa, `CMD_POLL);
        n = top(r, `RST_LOWEST_LINE);
        rdchk(sa, {5'h10, n});
        r[n] = 1'b0;
        host_model_inst.wr(sa, `CMD_SEL_IN_SERVICE);
        rdchk(sa, 8'h01 << n);
        rdchk(sa, 8'h01 << n);
        host_model_inst.wr(sa, `CMD_NONSPEC_CLEAR);
        rdchk(sa, 8'h00);
        host_model_inst.wr(sa, `CMD_SEL_PENDING);
        rdchk(sa, r);
        take(`RST_LOWEST_LINE);
        req_is(8'h00);
        host_model_inst.wr(sa, `CMD_SPECIAL_ON);
        req_is(8'h01);
        host_model_inst.wr(sa, `CMD_SPECIAL_OFF);
        req_is(8'h00);
        host_model_inst.wr(sa, `CMD_ROT_NONSPEC);
        low = n;
        take(low);
        low = 3'($urandom);
        host_model_inst.wr(sa, {`CMD_SET_LOW_HI, low});
        host_model_inst.wr(sa, `CMD_SEL_IN_SERVICE);
        rdchk(sa, 8'h01 << n);
        host_model_inst.wr(sa, {`CMD_SPEC_HI, n});
        rdchk(sa, 8'h00);
        take(low);
        host_model_inst.wr(sa, {`CMD_ROT_SPEC_HI, n});
        rdchk(sa, 8'h00);
        low = n;
        take(low);
        // auto end mode: fresh edges on every line
        host_model_inst.wr(sa, `CMD_NONSPEC_CLEAR);
        auto_service_end_mode <= 1'b1;
        host_model_inst.wr(sa, `CMD_AUTO_ROT_ON);
        request_lines <= 8'h00;
        repeat (2) @(posedge sys_clk);
        request_lines <= 8'hff;
        r = 8'hff;
        take(low);
        rdchk(sa, 8'h00);
        low = n;
        take(low);
        low = n;
        host_model_inst.wr(sa, `CMD_AUTO_ROT_OFF);
        take(low);
        take(low);
        // masked lines keep their pending bit until unmasked
        m = 8'hff;
        host_model_inst.wr(ma, m);
        req_is(8'h00);
        n = top(r, low);
        m = (8'($urandom) & ~r) | (8'h01 << n);
        host_model_inst.wr(ma, m);
        take(low);
        m = 8'h00;
        host_model_inst.wr(ma, m);
        take(low);
        // level mode, and a code outside both groups that must be ignored
        host_model_inst.wr(sa, `CMD_SEL_PENDING);
        host_model_inst.wr(sa, 8'h1b);
        r = 8'($urandom) | 8'h01;
        edge_mode <= 1'b0;
        request_lines <= r;
        rdchk(sa, r);
        @(posedge sys_clk);
        request_lines <= 8'h00;
        rdchk(sa, 8'h00);
        final_report();
    end
endmodule
